/* include/ppc_regs.vh */
/*
 * Constants for the clock-synthesis loop control port: register offsets, field
 * positions, reset values, setting ranges and loop tuning values.
 * Assumes it is included by its bare name from the design files.
 */
// Function
// - Loop enable is active high and works as enable and reset together.
// - Enable low forces every generated clock low and drops lock.
// - Enable returning high starts a fresh acquisition on the reference.
// - Counter reset high returns counters to initial values, clears outputs, drops lock.
// - Counter reset falling restarts acquisition and re-synchronises to the reference.
// - Phase detector enable low mutes up/down; oscillator and outputs keep running.
// - Switchover request high starts a manual change of reference input.
// - Lock indicator is high while locked and low while out of lock.
// - Lock indicator may pulse during acquisition; consumers must tolerate it.
// - Outputs a and b feed the global network; ext feeds network and pin.
// - Primary and secondary reference inputs; the chosen one feeds the pre-scaler.
// - Feedback multiplier and post-scale dividers accept settings one through 32.
// - Pre-scaler accepts one through four; outputs are input times m over n over C.
`ifndef PPC_REGS_VH
`define PPC_REGS_VH

`define PPC_ADDR_W          8
`define PPC_DATA_W          32

`define PPC_OFF_CTRL        8'h00
`define PPC_OFF_DIVIDE      8'h04
`define PPC_OFF_POST        8'h08
`define PPC_OFF_STATUS      8'h0C
`define PPC_OFF_LOCKCFG     8'h10

`define PPC_SET_W           6
`define PPC_PRE_W           3
`define PPC_PERIOD_W        12
`define PPC_LOCKCNT_W       8

`define PPC_CTRL_EXT_OE     0
`define PPC_DIV_PRE_LSB     0
`define PPC_DIV_MULT_LSB    8
`define PPC_POST_A_LSB      0
`define PPC_POST_B_LSB      8
`define PPC_POST_EXT_LSB    16
`define PPC_LOCKCFG_LSB     0

`define PPC_ST_LOCK         0
`define PPC_ST_REF          1
`define PPC_ST_UP           2
`define PPC_ST_DOWN         3
`define PPC_ST_ACQ          4
`define PPC_ST_ENABLE       5
`define PPC_ST_PERIOD_LSB   16

`define PPC_SET_MIN         6'h01
`define PPC_SET_MAX         6'h20
`define PPC_PRE_MIN         6'h01
`define PPC_PRE_MAX         6'h04

`define PPC_RST_CTRL_EXT_OE 1'h0
`define PPC_RST_PRE         3'h1
`define PPC_RST_MULT        6'h04
`define PPC_RST_POST        6'h01
`define PPC_RST_LOCK_GOOD   8'h10

`define PPC_PERIOD_INIT     12'h008
`define PPC_PERIOD_MIN      12'h001
`define PPC_PERIOD_MAX      12'hFFF

`endif

/* hdl/ppc_div_cell.v */
/*
 * One loop counter: counts input ticks, wraps after a programmable number of
 * them and toggles a level on every wrap. Used for the pre-scaler, the
 * feedback multiplier and the three post-scale dividers.
 * Assumes tick is a one-cycle pulse in the clk domain and div_value >= 1.
 */
`timescale 1ns/100ps
`include "ppc_regs.vh"

module ppc_div_cell (
    clk,
    rst_n,
    clear,
    tick,
    div_value,
    div_wrap,
    div_level
);
    input  wire                      clk;
    input  wire                      rst_n;
    input  wire                      clear;
    input  wire                      tick;
    input  wire [`PPC_SET_W-1:0]     div_value;
    output wire                      div_wrap;
    output reg                       div_level;

    reg  [`PPC_SET_W-2:0] count_reg;
    wire [`PPC_SET_W-1:0] last_value;

    assign last_value = div_value - `PPC_SET_MIN;
    assign div_wrap   = tick & ~clear & ({1'b0, count_reg} == last_value);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {(`PPC_SET_W-1){1'b0}};
            div_level <= 1'b0;
        end else if (clear) begin
            count_reg <= {(`PPC_SET_W-1){1'b0}};
            div_level <= 1'b0;
        end else if (div_wrap) begin
            count_reg <= {(`PPC_SET_W-1){1'b0}};
            div_level <= ~div_level;
        end else if (tick) begin
            count_reg <= count_reg + 1'b1;
        end
    end

endmodule // ppc_div_cell

/* hdl/ppc_pll_port_control.v */
/*
 * Control and status port of a digital model of the clock-synthesis loop:
 * loop enable, counter reset, phase detector enable, manual switchover,
 * lock indicator, the three post-scale outputs and the external clock pin,
 * plus a small register port for the divider settings and loop status.
 * Assumes all inputs, the reference inputs among them, are synchronous to clk
 * and that clk runs well above twice the reference frequency.
 */
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "ppc_regs.vh"

module ppc_pll_port_control #(
    parameter NUM_POST = 3
) (
    clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    ref_clk_primary,
    ref_clk_secondary,
    loop_enable,
    counter_reset,
    phase_det_enable,
    switchover_req,
    post_scale_out_a,
    post_scale_out_b,
    post_scale_out_ext,
    ext_clk_pin_out,
    ext_clk_pin_oe,
    lock_indicator,
    phase_detector_up,
    phase_detector_down,
    active_ref_secondary
);
    input  wire                   clk;
    input  wire                   rst_n;
    input  wire [`PPC_ADDR_W-1:0] reg_addr;
    input  wire [`PPC_DATA_W-1:0] reg_wdata;
    input  wire                   reg_wr;
    input  wire                   reg_rd;
    output reg  [`PPC_DATA_W-1:0] reg_rdata;
    input  wire                   ref_clk_primary;
    input  wire                   ref_clk_secondary;
    input  wire                   loop_enable;
    input  wire                   counter_reset;
    input  wire                   phase_det_enable;
    input  wire                   switchover_req;
    output wire                   post_scale_out_a;
    output wire                   post_scale_out_b;
    output wire                   post_scale_out_ext;
    output wire                   ext_clk_pin_out;
    output wire                   ext_clk_pin_oe;
    output wire                   lock_indicator;
    output wire                   phase_detector_up;
    output wire                   phase_detector_down;
    output wire                   active_ref_secondary;

    // Settings are clamped into their legal range on write, so the counters
    // never see a zero or oversized divide value.
    function [`PPC_SET_W-1:0] ppc_clamp;
        input [`PPC_SET_W-1:0] value;
        input [`PPC_SET_W-1:0] lo;
        input [`PPC_SET_W-1:0] hi;
        begin
            if (value < lo) begin
                ppc_clamp = lo;
            end else if (value > hi) begin
                ppc_clamp = hi;
            end else begin
                ppc_clamp = value;
            end
        end
    endfunction

    // Register file.
    reg                         ext_oe_reg;
    reg  [`PPC_PRE_W-1:0]       pre_scale_reg;
    reg  [`PPC_SET_W-1:0]       mult_reg;
    reg  [`PPC_SET_W-1:0]       post_a_reg;
    reg  [`PPC_SET_W-1:0]       post_b_reg;
    reg  [`PPC_SET_W-1:0]       post_ext_reg;
    reg  [`PPC_LOCKCNT_W-1:0]   lock_good_reg;
    reg  [`PPC_DATA_W-1:0]      read_next;
    wire [`PPC_SET_W-1:0]       pre_clamped;

    // Control input tracking and reference selection.
    reg                         switch_prev_reg;
    reg                         active_ref_reg;
    reg                         ref_prev_reg;
    wire                        switch_pulse;
    wire                        loop_hold;
    wire                        ref_sel;
    wire                        ref_rise;

    // Oscillator model.
    reg  [`PPC_PERIOD_W-1:0]    osc_period_reg;
    reg  [`PPC_PERIOD_W-1:0]    osc_cnt_reg;
    reg                         osc_level_reg;
    wire                        osc_half;
    wire                        osc_rise;

    // Phase detector and lock detector.
    reg  [1:0]                  fb_seen_reg;
    reg                         cmp_armed_reg;
    reg                         pd_up_reg;
    reg                         pd_down_reg;
    reg  [`PPC_LOCKCNT_W-1:0]   lock_cnt_reg;
    reg                         locked_reg;
    wire                        ref_tick;
    wire                        fb_tick;
    wire                        cmp_slow;
    wire                        cmp_fast;
    wire                        cmp_valid;

    wire [NUM_POST*`PPC_SET_W-1:0] post_bus;
    wire [NUM_POST-1:0]            post_level;
    assign pre_clamped = ppc_clamp({3'h0, reg_wdata[`PPC_DIV_PRE_LSB +: `PPC_PRE_W]},
                                   `PPC_PRE_MIN, `PPC_PRE_MAX);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_oe_reg    <= `PPC_RST_CTRL_EXT_OE;
            pre_scale_reg <= `PPC_RST_PRE;
            mult_reg      <= `PPC_RST_MULT;
            post_a_reg    <= `PPC_RST_POST;
            post_b_reg    <= `PPC_RST_POST;
            post_ext_reg  <= `PPC_RST_POST;
            lock_good_reg <= `PPC_RST_LOCK_GOOD;
        end else if (reg_wr) begin
            case (reg_addr)
                `PPC_OFF_CTRL: begin
                    ext_oe_reg <= reg_wdata[`PPC_CTRL_EXT_OE];
                end
                `PPC_OFF_DIVIDE: begin
                    pre_scale_reg <= pre_clamped[`PPC_PRE_W-1:0];
                    mult_reg      <= ppc_clamp(reg_wdata[`PPC_DIV_MULT_LSB +: `PPC_SET_W],
                                               `PPC_SET_MIN, `PPC_SET_MAX);
                end
                `PPC_OFF_POST: begin
                    post_a_reg   <= ppc_clamp(reg_wdata[`PPC_POST_A_LSB +: `PPC_SET_W],
                                              `PPC_SET_MIN, `PPC_SET_MAX);
                    post_b_reg   <= ppc_clamp(reg_wdata[`PPC_POST_B_LSB +: `PPC_SET_W],
                                              `PPC_SET_MIN, `PPC_SET_MAX);
                    post_ext_reg <= ppc_clamp(reg_wdata[`PPC_POST_EXT_LSB +: `PPC_SET_W],
                                              `PPC_SET_MIN, `PPC_SET_MAX);
                end
                `PPC_OFF_LOCKCFG: begin
                    lock_good_reg <= reg_wdata[`PPC_LOCKCFG_LSB +: `PPC_LOCKCNT_W];
                end
                default: lock_good_reg <= lock_good_reg;
            endcase
        end
    end

    always @* begin
        read_next = {`PPC_DATA_W{1'b0}};
        case (reg_addr)
            `PPC_OFF_CTRL: begin
                read_next[`PPC_CTRL_EXT_OE] = ext_oe_reg;
            end
            `PPC_OFF_DIVIDE: begin
                read_next[`PPC_DIV_PRE_LSB +: `PPC_PRE_W]  = pre_scale_reg;
                read_next[`PPC_DIV_MULT_LSB +: `PPC_SET_W] = mult_reg;
            end
            `PPC_OFF_POST: begin
                read_next[`PPC_POST_A_LSB +: `PPC_SET_W]   = post_a_reg;
                read_next[`PPC_POST_B_LSB +: `PPC_SET_W]   = post_b_reg;
                read_next[`PPC_POST_EXT_LSB +: `PPC_SET_W] = post_ext_reg;
            end
            `PPC_OFF_STATUS: begin
                read_next[`PPC_ST_LOCK]   = locked_reg;
                read_next[`PPC_ST_REF]    = active_ref_reg;
                read_next[`PPC_ST_UP]     = pd_up_reg;
                read_next[`PPC_ST_DOWN]   = pd_down_reg;
                read_next[`PPC_ST_ACQ]    = loop_enable & ~locked_reg;
                read_next[`PPC_ST_ENABLE] = loop_enable;
                read_next[`PPC_ST_PERIOD_LSB +: `PPC_PERIOD_W] = osc_period_reg;
            end
            `PPC_OFF_LOCKCFG: begin
                read_next[`PPC_LOCKCFG_LSB +: `PPC_LOCKCNT_W] = lock_good_reg;
            end
            default: begin
                read_next = {`PPC_DATA_W{1'b0}};
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= {`PPC_DATA_W{1'b0}};
        end else if (reg_rd) begin
            reg_rdata <= read_next;
        end else begin
            reg_rdata <= {`PPC_DATA_W{1'b0}};
        end
    end

    // A switchover is a restart on the other reference, so it joins the hold
    // term for one cycle and every loop counter starts again from zero.
    assign switch_pulse = switchover_req & ~switch_prev_reg & loop_enable;
    assign loop_hold    = ~loop_enable | counter_reset | switch_pulse;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switch_prev_reg <= 1'b0;
            active_ref_reg  <= 1'b0;
        end else begin
            switch_prev_reg <= switchover_req;
            if (switch_pulse) begin
                active_ref_reg <= ~active_ref_reg;
            end
        end
    end

    // Only the two reference pins reach the pre-scaler; the reference edge is
    // found by sampling, which is why clk must be much faster than it.
    assign ref_sel  = active_ref_reg ? ref_clk_secondary : ref_clk_primary;
    assign ref_rise = ref_sel & ~ref_prev_reg & ~loop_hold;

    // Holding the previous sample high during a hold keeps a reference that is
    // already high from looking like a fresh edge after the restart.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev_reg <= 1'b1;
        end else if (loop_hold) begin
            ref_prev_reg <= 1'b1;
        end else begin
            ref_prev_reg <= ref_sel;
        end
    end

    // The oscillator is a programmable half-period counter. It stops only with
    // the loop enable; counter reset and a muted detector leave it running.
    // Comparing with >= keeps a period cut below the count from wrapping it.
    assign osc_half = loop_enable & (osc_cnt_reg >= osc_period_reg - `PPC_PERIOD_MIN);
    assign osc_rise = osc_half & ~osc_level_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_reg   <= {`PPC_PERIOD_W{1'b0}};
            osc_level_reg <= 1'b0;
        end else if (!loop_enable) begin
            osc_cnt_reg   <= {`PPC_PERIOD_W{1'b0}};
            osc_level_reg <= 1'b0;
        end else if (osc_half) begin
            osc_cnt_reg   <= {`PPC_PERIOD_W{1'b0}};
            osc_level_reg <= ~osc_level_reg;
        end else begin
            osc_cnt_reg   <= osc_cnt_reg + 1'b1;
        end
    end

    // Up shortens the half period (faster), down lengthens it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_period_reg <= `PPC_PERIOD_INIT;
        end else if (!loop_enable) begin
            osc_period_reg <= `PPC_PERIOD_INIT;
        end else if (pd_up_reg && osc_period_reg > `PPC_PERIOD_MIN) begin
            osc_period_reg <= osc_period_reg - 1'b1;
        end else if (pd_down_reg && osc_period_reg < `PPC_PERIOD_MAX) begin
            osc_period_reg <= osc_period_reg + 1'b1;
        end
    end

    ppc_div_cell u_pre_scale (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (loop_hold),
        .tick      (ref_rise),
        .div_value ({3'h0, pre_scale_reg}),
        .div_wrap  (ref_tick),
        .div_level ()
    );

    ppc_div_cell u_feedback (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (loop_hold),
        .tick      (osc_rise),
        .div_value (mult_reg),
        .div_wrap  (fb_tick),
        .div_level ()
    );

    assign post_bus = {post_ext_reg, post_b_reg, post_a_reg};

    // Each post-scale divider counts oscillator half periods, so a setting of
    // C gives one output period per C oscillator periods.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_POST; gi = gi + 1) begin : g_post
            ppc_div_cell u_post (
                .clk       (clk),
                .rst_n     (rst_n),
                .clear     (loop_hold),
                .tick      (osc_half),
                .div_value (post_bus[gi*`PPC_SET_W +: `PPC_SET_W]),
                .div_wrap  (),
                .div_level (post_level[gi])
            );
        end
    endgenerate

    // The detector checks that exactly one feedback edge fell in each
    // pre-scaled reference period. The first reference tick after a restart
    // only opens the window, since nothing before it is trustworthy.
    assign cmp_valid = ref_tick & cmp_armed_reg;
    assign cmp_slow  = (fb_seen_reg == 2'h0);
    assign cmp_fast  = (fb_seen_reg >= 2'h2);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_seen_reg   <= 2'h0;
            cmp_armed_reg <= 1'b0;
        end else if (loop_hold) begin
            fb_seen_reg   <= 2'h0;
            cmp_armed_reg <= 1'b0;
        end else if (ref_tick) begin
            fb_seen_reg   <= {1'b0, fb_tick};
            cmp_armed_reg <= 1'b1;
        end else if (fb_tick && fb_seen_reg != 2'h3) begin
            fb_seen_reg   <= fb_seen_reg + 2'h1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_up_reg   <= 1'b0;
            pd_down_reg <= 1'b0;
        end else begin
            pd_up_reg   <= cmp_valid & cmp_slow & phase_det_enable & ~loop_hold;
            pd_down_reg <= cmp_valid & cmp_fast & phase_det_enable & ~loop_hold;
        end
    end

    // Lock needs a run of good windows; any bad window drops it at once, so the
    // indicator can chatter while the loop settles.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_reg <= {`PPC_LOCKCNT_W{1'b0}};
            locked_reg   <= 1'b0;
        end else if (loop_hold) begin
            lock_cnt_reg <= {`PPC_LOCKCNT_W{1'b0}};
            locked_reg   <= 1'b0;
        end else if (cmp_valid) begin
            if (cmp_slow || cmp_fast) begin
                lock_cnt_reg <= {`PPC_LOCKCNT_W{1'b0}};
                locked_reg   <= 1'b0;
            end else if (lock_cnt_reg >= lock_good_reg) begin
                locked_reg   <= 1'b1;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 1'b1;
            end
        end
    end

    assign post_scale_out_a     = post_level[0];
    assign post_scale_out_b     = post_level[1];
    assign post_scale_out_ext   = post_level[2];
    assign ext_clk_pin_out      = post_level[2];
    assign ext_clk_pin_oe       = ext_oe_reg;
    assign lock_indicator       = locked_reg;
    assign phase_detector_up    = pd_up_reg;
    assign phase_detector_down  = pd_down_reg;
    assign active_ref_secondary = active_ref_reg;

endmodule // ppc_pll_port_control

/* bench/ppc_port_checker.sv */
/*
 * Port checker for the loop control block: control inputs against clocks, lock and detector.
 * Assumes it is bound to the top module and that every signal belongs to clk.
 */
`timescale 1ns/100ps

module ppc_port_checker (
    input wire clk,
    input wire rst_n,
    input wire loop_enable,
    input wire counter_reset,
    input wire phase_det_enable,
    input wire switchover_req,
    input wire post_scale_out_a,
    input wire post_scale_out_b,
    input wire post_scale_out_ext,
    input wire ext_clk_pin_out,
    input wire lock_indicator,
    input wire phase_detector_up,
    input wire phase_detector_down,
    input wire active_ref_secondary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire any_out = post_scale_out_a | post_scale_out_b | post_scale_out_ext;

    sequence seq_restart;
        ($rose(loop_enable) && !counter_reset) || ($fell(counter_reset) && loop_enable);
    endsequence
    // The loop may be stopped again before the first toggle; that also ends the wait.
    sequence seq_toggle;
        ##[1:700] ($changed(post_scale_out_a) || !loop_enable || counter_reset);
    endsequence

    chk_disable_clears_outs: assert property (!loop_enable |=> !any_out)
        else $error("clock output high while the loop is disabled");
    chk_creset_clears_outs: assert property (counter_reset |=> !any_out)
        else $error("clock output high while counters are held in reset");
    chk_hold_drops_lock: assert property ((!loop_enable || counter_reset) |=> !lock_indicator)
        else $error("lock indicator high while the loop is held");
    chk_detector_muted: assert property (!phase_det_enable |=> !(phase_detector_up || phase_detector_down))
        else $error("detector pulse while the detector is disabled");
    chk_disable_mutes_pd: assert property (!loop_enable |=> !(phase_detector_up || phase_detector_down))
        else $error("detector pulse while the loop is disabled");
    chk_ext_pin_mirror: assert property (ext_clk_pin_out == post_scale_out_ext)
        else $error("external pin differs from the shared output");
    chk_restart_toggle: assert property (seq_restart |-> seq_toggle)
        else $error("outputs did not resume after restart");
    chk_switch_swaps: assert property ($rose(switchover_req) && loop_enable |-> ##[1:2] $changed(active_ref_secondary))
        else $error("switchover request did not change the reference");
endmodule // ppc_port_checker

/* bench/ppc_fabric_model.sv */
/*
 * Fabric-side partner: two free-running reference clocks and detector enable control.
 * Assumes the references are far slower than clk and that ref_run stops both of them.
 */
`timescale 1ns/100ps

module ppc_fabric_model #(
    parameter HALF_P = 20,
    parameter HALF_S = 40,
    parameter STALE  = 100
) (
    input  wire clk,
    input  wire rst_n,
    input  wire ref_run,
    output reg  ref_clk_primary,
    output reg  ref_clk_secondary,
    output reg  phase_det_enable
);
    reg [7:0] cnt_p;
    reg [7:0] cnt_s;
    reg [7:0] quiet;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_p <= 8'h00;
            cnt_s <= 8'h00;
            quiet <= 8'h00;
            ref_clk_primary <= 1'b0;
            ref_clk_secondary <= 1'b0;
            phase_det_enable <= 1'b0;
        end else begin
            if (ref_run) begin
                cnt_p <= (cnt_p == 8'(HALF_P - 1)) ? 8'h00 : cnt_p + 8'h01;
                cnt_s <= (cnt_s == 8'(HALF_S - 1)) ? 8'h00 : cnt_s + 8'h01;
                ref_clk_primary <= ref_clk_primary ^ (cnt_p == 8'(HALF_P - 1));
                ref_clk_secondary <= ref_clk_secondary ^ (cnt_s == 8'(HALF_S - 1));
            end
            // A dead reference is only trusted gone after STALE cycles of silence.
            quiet <= ref_run ? 8'h00 : ((quiet == 8'(STALE)) ? quiet : quiet + 8'h01);
            phase_det_enable <= (quiet != 8'(STALE));
        end
    end
endmodule // ppc_fabric_model

/* bench/tb_top.sv */
/*
 * Self-checking bench for the loop control port: registers, lock, hold and switchover.
 * Assumes the fabric model supplies references and detector enable.
 */
`timescale 1ns/100ps
`include "ppc_regs.vh"

module tb_top;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ref_run = 1'b1;
    logic        loop_enable = 1'b0, counter_reset = 1'b0, switchover_req = 1'b0, pa;
    wire  [31:0] reg_rdata;
    wire ref_clk_primary, ref_clk_secondary, phase_det_enable, post_scale_out_a;
    wire post_scale_out_b, post_scale_out_ext, ext_clk_pin_out, ext_clk_pin_oe;
    wire lock_indicator, phase_detector_up, phase_detector_down, active_ref_secondary;
    logic [31:0] wv [4] = '{32'h00003F07, 32'h00000000, 32'h00000103, 32'h00000401};
    logic [31:0] ev [4] = '{32'h00002004, 32'h00000101, 32'h00000103, 32'h00000401};
    int num_errors = 0;
    int samples_checked = 0;
    int n;

    initial begin
        forever #20 clk = ~clk;
    end

    ppc_fabric_model u_fab (.*);
    ppc_pll_port_control dut (.*);

    task final_report;
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        chk_word({31'h00000000, got}, {31'h00000000, exp});
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk_word(reg_rdata & m, exp);
    endtask
    // Returns at the first high sample of the lock indicator, so a lock pulse during acquisition ends the wait.
    task wait_lock;
        n = 0;
        while (lock_indicator !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (lock_indicator !== 1'b1) begin
            chk_bit(lock_indicator, 1'b1);
            final_report;
        end
    endtask
    task pulse_switch;
        @(posedge clk);
        switchover_req <= 1'b1;
        @(posedge clk);
        switchover_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(`PPC_OFF_CTRL, 32'hFFFFFFFF, 32'h00000000);
        rd(`PPC_OFF_DIVIDE, 32'hFFFFFFFF, 32'h00000401);
        rd(`PPC_OFF_POST, 32'hFFFFFFFF, 32'h00010101);
        rd(`PPC_OFF_LOCKCFG, 32'hFFFFFFFF, 32'h00000010);
        rd(8'h14, 32'hFFFFFFFF, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            wr(`PPC_OFF_DIVIDE, wv[i]);
            rd(`PPC_OFF_DIVIDE, 32'hFFFFFFFF, ev[i]);
        end
        wr(`PPC_OFF_POST, 32'h00203F00);
        rd(`PPC_OFF_POST, 32'hFFFFFFFF, 32'h00202001);
        wr(`PPC_OFF_POST, 32'h00010102);
        wr(`PPC_OFF_CTRL, 32'h00000001);
        @(negedge clk);
        chk_bit(ext_clk_pin_oe, 1'b1);
        @(posedge clk);
        loop_enable <= 1'b1;
        wait_lock;
        rd(`PPC_OFF_STATUS, 32'h0FFF0031, 32'h00050021);
        @(posedge clk);
        counter_reset <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk_bit(lock_indicator, 1'b0);
        rd(`PPC_OFF_STATUS, 32'h0FFF0000, 32'h00050000);
        @(posedge clk);
        counter_reset <= 1'b0;
        wait_lock;
        pulse_switch;
        #1 chk_bit(active_ref_secondary, 1'b1);
        wait_lock;
        rd(`PPC_OFF_STATUS, 32'h0FFF0003, 32'h000A0003);
        pulse_switch;
        rd(`PPC_OFF_STATUS, 32'h00000002, 32'h00000000);
        wait_lock;
        @(posedge clk);
        ref_run <= 1'b0;
        repeat (120) @(posedge clk);
        n = 0;
        pa = post_scale_out_a;
        repeat (200) begin
            @(posedge clk);
            #1 if (post_scale_out_a !== pa) n++;
            pa = post_scale_out_a;
        end
        chk_bit(n > 10, 1'b1);
        @(posedge clk);
        loop_enable <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk_bit(lock_indicator | post_scale_out_a | post_scale_out_ext, 1'b0);
        rd(`PPC_OFF_STATUS, 32'h0FFF0020, 32'h00080000);
        @(posedge clk);
        ref_run <= 1'b1;
        loop_enable <= 1'b1;
        wait_lock;
        final_report;
    end
endmodule // tb_top

bind ppc_pll_port_control ppc_port_checker u_chk (.clk, .rst_n, .loop_enable, .counter_reset,
    .phase_det_enable, .switchover_req, .post_scale_out_a, .post_scale_out_b,
    .post_scale_out_ext, .ext_clk_pin_out, .lock_indicator, .phase_detector_up,
    .phase_detector_down, .active_ref_secondary);
